// >>> core/sio_ctrl.sv
// Serial control-port host: APB register front end driving the serial chain
`include "sio_ctrl_params.svh"
module sio_ctrl
  import sio_ctrl_pkg::*;
#(
  parameter int DIV = 4
)(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             SCK,
  output logic             CMD,
  input  wire logic        SIO_I,
  output logic             SIO_O,
  output logic             SIO_OE
);

  // Opcodes that may appear on the line
  function automatic logic op_legal(input op_t op);
    op_legal = (op == `OP_READ) || (op == `OP_WRITE) || (op == `OP_SET_RESET_CMD) ||
               (op == `OP_FAST_CLOCK_CMD) || (op == `OP_CLEAR_RESET_CMD) || (op == `OP_NOP);
  endfunction : op_legal

  // Idle serial cycles owed after a request
  function automatic logic [4:0] gap_len(input op_t op);
    case (op)
      `OP_SET_RESET_CMD: gap_len = `GAP_SET_RESET_CMD;
      `OP_FAST_CLOCK_CMD: gap_len = `GAP_FAST_CLOCK_CMD;
      `OP_CLEAR_RESET_CMD: gap_len = `GAP_CLEAR_RESET_CMD;
      default:  gap_len = `GAP_MIN;
    endcase
  endfunction : gap_len

  // Register targeted by each init step
  function automatic logic [11:0] step_addr(input logic [3:0] s);
    case (s)
      4'h1:    step_addr = `SA_CYCLE;
      4'h2:    step_addr = `SA_RDTIM;
      4'h3:    step_addr = `SA_COLDLY;
      4'h4:    step_addr = `SA_FRAMING;
      4'h5:    step_addr = `SA_POWERDOWN_EXIT_REG;
      4'h6:    step_addr = `SA_POWERDOWN_EXIT_AUX_REG;
      4'h7:    step_addr = `SA_NAP_EXIT_REG;
      default: step_addr = `SA_T77;
    endcase
  endfunction : step_addr

  st_e         st_q;
  op_t         op_q;
  logic        bc_q;
  logic [5:0]  dev_q;
  logic [11:0] addr_q;
  logic [15:0] data_q;
  logic [2:0]  pkt_q;
  logic [3:0]  bit_q;
  logic [4:0]  gap_q;
  logic        pair_q;
  logic [15:0] rsh_q;
  logic        sio_o_q;
  logic        sio_oe_q;
  logic [7:0]  div_q;
  logic        sck_q;
  logic [7:0]  frame_q;
  logic        cmd_q;
  logic        sio_s1_q;
  logic        sio_s2_q;
  op_t         c_op_q;
  logic        c_bc_q;
  logic [5:0]  c_dev_q;
  logic [11:0] a_q;
  logic [15:0] wd_q;
  logic [15:0] tbl_q [0:7];
  logic        go_q;
  logic        init_q;
  logic [3:0]  step_q;
  logic        done_q;
  logic        t77_q;
  logic [3:0]  err_q;
  logic [15:0] rdata_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        tick_end;
  logic        rise;
  logic        fall;
  logic        mid;
  logic        busy;
  logic        launch;
  op_t         l_op;
  logic        l_bc;
  logic [5:0]  l_dev;
  logic [11:0] l_addr;
  logic [15:0] l_data;
  logic [15:0] cur_word;
  logic [2:0]  n_pkt;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_val;
  logic [3:0]  cmd_err;
  logic        cmd_ok;
  logic        init_go;

  // Serial clock divider; edges are seen as ticks in the CLOCK domain
  assign tick_end = (div_q == 8'(DIV - 1));
  assign rise     = tick_end && !sck_q;
  assign fall     = tick_end && sck_q;
  assign mid      = (div_q == 8'(DIV / 2 - 1)); // Mid half period, DIV of 2 or more

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      div_q <= 8'h00;
      sck_q <= 1'b0;
    end
    else if (tick_end)
    begin
      div_q <= 8'h00;
      sck_q <= !sck_q;
    end
    else
      div_q <= div_q + 8'h01;
  end

  // Two-stage synchroniser for returning read data
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      sio_s1_q <= 1'b0;
      sio_s2_q <= 1'b0;
    end
    else
    begin
      sio_s1_q <= SIO_I;
      sio_s2_q <= sio_s1_q;
    end
  end

  // Next request: the init sequencer takes precedence over software
  assign busy = (st_q != ST_IDLE) || go_q || init_q;

  always_comb
  begin
    launch = 1'b0;
    l_op   = c_op_q;
    l_bc   = c_bc_q;
    l_dev  = c_dev_q;
    l_addr = a_q;
    l_data = wd_q;
    if (st_q == ST_IDLE && init_q && step_q <= `INIT_LAST)
    begin
      launch = 1'b1;
      l_bc   = 1'b1;
      l_dev  = 6'h00;
      if (step_q == `INIT_LAST)
        l_op = `OP_SET_RESET_CMD;
      else
      begin
        l_op   = `OP_WRITE;
        l_addr = step_addr(step_q);
        l_data = (step_q == 4'h0) ? 16'h0000 : tbl_q[step_q[2:0]];
      end
    end
    else if (st_q == ST_IDLE && go_q)
      launch = 1'b1;
  end

  // Packet contents; reserved positions stay zero
  always_comb
  begin
    case (pkt_q)
      3'h0:    cur_word = {5'h00, dev_q[5], op_q, bc_q, dev_q[4:0]};
      3'h1:    cur_word = {4'h0, addr_q};
      3'h2:    cur_word = (op_q == `OP_WRITE) ? data_q : 16'h0000;
      default: cur_word = 16'h0000;
    endcase
    case (op_q)
      `OP_READ:  n_pkt = 3'h3;
      `OP_WRITE: n_pkt = 3'h4;
      default:   n_pkt = 3'h1;
    endcase
  end

  // Transfer sequencer; bits change on rising serial edges
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      st_q     <= ST_IDLE;
      op_q     <= `OP_NOP;
      bc_q     <= 1'b0;
      dev_q    <= 6'h00;
      addr_q   <= 12'h000;
      data_q   <= 16'h0000;
      pkt_q    <= 3'h0;
      bit_q    <= 4'h0;
      gap_q    <= 5'h00;
      pair_q   <= 1'b0;
      rsh_q    <= 16'h0000;
      sio_o_q  <= 1'b0;
      sio_oe_q <= 1'b1;
    end
    else
      case (st_q)
        ST_IDLE:
          if (launch)
          begin
            st_q   <= ST_SEND;
            op_q   <= l_op;
            bc_q   <= l_bc;
            dev_q  <= l_dev;
            addr_q <= l_addr;
            data_q <= l_data;
            pkt_q  <= 3'h0;
            bit_q  <= 4'h0;
            pair_q <= (l_op == `OP_SET_RESET_CMD);
          end
        ST_SEND:
          if (rise)
          begin
            if (pkt_q == n_pkt)
            begin
              sio_o_q <= 1'b0;
              bit_q   <= 4'h0;
              if (op_q == `OP_READ)
              begin
                st_q     <= ST_RECV;
                sio_oe_q <= 1'b0;
              end
              else
              begin
                st_q  <= ST_GAP;
                gap_q <= gap_len(op_q);
              end
            end
            else
            begin
              sio_o_q <= cur_word[~bit_q]; // Most significant bit first
              bit_q   <= bit_q + 4'h1;
              if (bit_q == `LAST_BIT)
                pkt_q <= pkt_q + 3'h1;
            end
          end
        ST_RECV:
          if (fall)
          begin
            rsh_q <= {rsh_q[14:0], sio_s2_q};
            bit_q <= bit_q + 4'h1;
            if (bit_q == `LAST_BIT)
            begin
              st_q  <= ST_GAP;
              gap_q <= gap_len(op_q);
            end
          end
        ST_GAP:
          if (rise)
          begin
            sio_oe_q <= 1'b1; // Resume driving zero after a read
            if (gap_q == `GAP_MIN)
            begin
              if (pair_q && op_q == `OP_SET_RESET_CMD)
              begin
                op_q  <= `OP_CLEAR_RESET_CMD;
                st_q  <= ST_SEND;
                pkt_q <= 3'h0;
                bit_q <= 4'h0;
              end
              else
              begin
                st_q   <= ST_IDLE;
                pair_q <= 1'b0;
              end
            end
            else
              gap_q <= gap_q - 5'h01;
          end
        default:
          st_q <= ST_IDLE;
      endcase
  end

  // Framing shifts out mid half period so both edges see stable levels
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      frame_q <= 8'h00;
      cmd_q   <= 1'b0;
    end
    else if (rise && st_q == ST_SEND && pkt_q == 3'h0 && bit_q == 4'h0)
      frame_q <= `FRAME_PAT;
    else if (mid)
    begin
      cmd_q   <= frame_q[7];
      frame_q <= {frame_q[6:0], 1'b0};
    end
  end

  // Captured read word
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      rdata_q <= 16'h0000;
    else if (st_q == ST_RECV && fall && bit_q == `LAST_BIT)
      rdata_q <= {rsh_q[14:0], sio_s2_q};
  end

  // APB decode; effects happen at the edge that samples PREADY high
  assign acc    = PSEL && PENABLE && pready_q;
  assign wr     = acc && PWRITE;
  assign mapped = (PADDR == `A_CMD) || (PADDR == `A_ADDR) || (PADDR == `A_WDATA) ||
                  (PADDR == `A_STAT) || (PADDR == `A_RDATA) ||
                  (PADDR[7:5] == `A_TBL && PADDR[1:0] == 2'h0);
  assign init_go = wr && PADDR == `A_CMD && PWDATA[`CMD_INIT] && !busy;

  // Checks on a launch request; refused ones only raise a status flag
  always_comb
  begin
    cmd_err = 4'h0;
    cmd_ok  = 1'b0;
    if (wr && PADDR == `A_CMD && (PWDATA[`CMD_GO] || PWDATA[`CMD_INIT]))
    begin
      if (busy)
        cmd_err[1] = 1'b1;
      else if (!PWDATA[`CMD_GO])
        cmd_ok = 1'b0;
      else if (!op_legal(PWDATA[3:0]) || PWDATA[3:0] == `OP_CLEAR_RESET_CMD)
        cmd_err[0] = 1'b1;
      else if ((PWDATA[3:0] == `OP_READ || PWDATA[3:0] == `OP_WRITE) &&
               t77_q && a_q != `SA_T77)
        cmd_err[2] = 1'b1;
      else if (PWDATA[3:0] == `OP_WRITE && wd_q[5] &&
               (a_q == `SA_INIT || a_q == `SA_MEMID))
        cmd_err[3] = 1'b1;
      else
        cmd_ok = 1'b1;
    end
  end

  // Software-written command, address, data and init table
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      c_op_q  <= `OP_NOP;
      c_bc_q  <= 1'b0;
      c_dev_q <= 6'h00;
      a_q     <= 12'h000;
      wd_q    <= 16'h0000;
      for (int i = 0; i < 8; i++)
        tbl_q[i] <= 16'h0000;
    end
    else if (wr && !busy)
    begin
      if (PADDR == `A_CMD)
      begin
        c_op_q  <= PWDATA[3:0];
        c_bc_q  <= PWDATA[`CMD_BC];
        c_dev_q <= PWDATA[13:8];
      end
      if (PADDR == `A_ADDR)
        a_q <= PWDATA[11:0];
      if (PADDR == `A_WDATA)
        wd_q <= PWDATA[15:0];
      if (PADDR[7:5] == `A_TBL && PADDR[1:0] == 2'h0)
        tbl_q[PADDR[4:2]] <= PWDATA[15:0];
    end
  end

  // Launch request and init sequencer progress
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      go_q   <= 1'b0;
      init_q <= 1'b0;
      step_q <= 4'h0;
      done_q <= 1'b0;
    end
    else
    begin
      if (cmd_ok)
        go_q <= 1'b1;
      else if (launch && !init_q)
        go_q <= 1'b0;
      if (init_go)
      begin
        init_q <= 1'b1;
        step_q <= 4'h0;
        done_q <= 1'b0;
      end
      else if (launch && init_q)
        step_q <= step_q + 4'h1;
      else if (init_q && st_q == ST_IDLE && step_q == `INIT_DONE)
      begin
        init_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  // Test register 77 must be zeroed first after reset
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      t77_q <= 1'b1;
    else if (launch && l_op == `OP_WRITE && l_addr == `SA_T77 && l_data == 16'h0000)
      t77_q <= 1'b0;
  end

  // Sticky refusal flags, write one to clear; a new refusal wins
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      err_q <= 4'h0;
    else if (wr && PADDR == `A_STAT)
      err_q <= (err_q & ~PWDATA[4:1]) | cmd_err;
    else
      err_q <= err_q | cmd_err;
  end

  // Read mux
  always_comb
  begin
    case (PADDR)
      `A_CMD:   rd_val = {18'h00000, c_dev_q, 3'h0, c_bc_q, c_op_q};
      `A_ADDR:  rd_val = {20'h00000, a_q};
      `A_WDATA: rd_val = {16'h0000, wd_q};
      `A_STAT:  rd_val = {25'h0000000, done_q, t77_q, err_q, busy};
      `A_RDATA: rd_val = {16'h0000, rdata_q};
      default:  rd_val = mapped ? {16'h0000, tbl_q[PADDR[4:2]]} : 32'h00000000;
    endcase
  end

  // One wait state on every APB access
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= PSEL && PENABLE && !pready_q;
      prdata_q  <= (PSEL && PENABLE && !pready_q && !PWRITE) ? rd_val : 32'h00000000;
      pslverr_q <= PSEL && PENABLE && !pready_q && !mapped;
    end
  end

  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;
  assign SCK     = sck_q;
  assign CMD     = cmd_q;
  assign SIO_O   = sio_o_q;
  assign SIO_OE  = sio_oe_q;

  // Checks on the line sequencing
  rsv_bits_a: assert property (@(posedge CLOCK) disable iff (RST)
    (st_q == ST_SEND && pkt_q == 3'h0) |-> cur_word[15:11] == 5'h00)
    else $error("reserved request bits not zero");
  legal_op_a: assert property (@(posedge CLOCK) disable iff (RST)
    (st_q != ST_IDLE) |-> op_legal(op_q))
    else $error("reserved opcode on the line");
  set_reset_cmd_gap_a: assert property (@(posedge CLOCK) disable iff (RST)
    ($rose(st_q == ST_GAP) && op_q == `OP_SET_RESET_CMD) |-> gap_q == 5'h10)
    else $error("set-reset gap wrong");
  fast_gap_a: assert property (@(posedge CLOCK) disable iff (RST)
    ($rose(st_q == ST_GAP) && op_q == `OP_FAST_CLOCK_CMD) |-> gap_q == 5'h04)
    else $error("fast clock gap wrong");
  clear_reset_cmd_gap_a: assert property (@(posedge CLOCK) disable iff (RST)
    ($rose(st_q == ST_GAP) && op_q == `OP_CLEAR_RESET_CMD) |-> gap_q == 5'h04)
    else $error("clear-reset gap wrong");
  reset_pair_a: assert property (@(posedge CLOCK) disable iff (RST)
    (st_q == ST_GAP && op_q == `OP_SET_RESET_CMD && gap_q == `GAP_MIN && rise)
    |=> (st_q == ST_SEND && op_q == `OP_CLEAR_RESET_CMD))
    else $error("set-reset not followed by clear-reset");
  t77_first_a: assert property (@(posedge CLOCK) disable iff (RST)
    (launch && t77_q && (l_op == `OP_READ || l_op == `OP_WRITE)) |-> l_addr == `SA_T77)
    else $error("access before test register zeroed");
  frame_load_a: assert property (@(posedge CLOCK) disable iff (RST)
    (rise && st_q == ST_SEND && pkt_q == 3'h0 && bit_q == 4'h0) |=> frame_q == `FRAME_PAT)
    else $error("request not framed");
  read_turn_a: assert property (@(posedge CLOCK) disable iff (RST)
    $fell(SIO_OE) |-> ($past(op_q) == `OP_READ && $past(pkt_q) == 3'h3))
    else $error("line released at wrong packet");
  read_len_a: assert property (@(posedge CLOCK) disable iff (RST)
    ($rose(st_q == ST_GAP) && op_q == `OP_READ) |-> $past(bit_q) == 4'hF)
    else $error("read data not sixteen bits");

endmodule : sio_ctrl

// >>> core/sio_ctrl_params.svh
// Constants for the serial control-port host
`ifndef SIO_CTRL_PARAMS_SVH
`define SIO_CTRL_PARAMS_SVH
// Serial opcodes
`define OP_READ    4'h0
`define OP_WRITE   4'h1
`define OP_SET_RESET_CMD    4'h2
`define OP_FAST_CLOCK_CMD    4'h4
`define OP_CLEAR_RESET_CMD    4'hB
`define OP_NOP     4'hF
// Framing pattern on the command line, one bit per serial clock edge
`define FRAME_PAT  8'hF0
// Idle serial cycles after each request kind
`define GAP_SET_RESET_CMD   5'h10
`define GAP_FAST_CLOCK_CMD   5'h04
`define GAP_CLEAR_RESET_CMD   5'h04
`define GAP_MIN    5'h01
`define LAST_BIT   4'hF
`define INIT_LAST  4'h8
`define INIT_DONE  4'h9
// APB register offsets
`define A_CMD      8'h00
`define A_ADDR     8'h04
`define A_WDATA    8'h08
`define A_STAT     8'h0C
`define A_RDATA    8'h10
`define A_TBL      3'h1
// Command register fields
`define CMD_BC     4
`define CMD_GO     16
`define CMD_INIT   17
// Serial register addresses
`define SA_INIT    12'h021
`define SA_T77     12'h101
`define SA_CYCLE   12'h102
`define SA_RDTIM   12'h103
`define SA_COLDLY  12'h104
`define SA_FRAMING 12'h105
`define SA_POWERDOWN_EXIT_REG    12'h106
`define SA_POWERDOWN_EXIT_AUX_REG   12'h107
`define SA_NAP_EXIT_REG    12'h108
`define SA_MEMID   12'h109
`endif

// >>> core/sio_ctrl_pkg.sv
// Types shared by the serial control-port host
package sio_ctrl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_RECV, ST_GAP} st_e;
  typedef logic [3:0] op_t;
endpackage : sio_ctrl_pkg

// >>> verification/sio_dev_model.sv
// Behavioural model of one memory device on the serial chain
`include "sio_ctrl_params.svh"
module sio_dev_model #(
  parameter logic [15:0] INIT_RST = 16'h00BF  // Repeater bit placed at bit 7 by guess
)(
  input  wire logic rst,
  input  wire logic sck,
  input  wire logic cmd,
  input  wire logic sio,
  output logic      line_o,
  output logic      rep_o,
  output int        frames,
  output int        errs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs [int];
  logic [15:0] sh, sa, rd;
  logic [7:0]  hist;
  logic [3:0]  op, prev;
  logic        sel, drv, bit_q, wr, t77p;
  int          ph, n, since, need;

  // Released line shows the inverse of the last bit, never a stale copy
  assign line_o = drv ? bit_q : ~bit_q;

  // Host data passes on down the chain; nothing sits below this device
  assign rep_o = sio;

  // Register file back to reset values
  task automatic wipe();
    regs.delete();
    regs[`SA_INIT] = INIT_RST;
  endtask : wipe

  task automatic restart();
    wipe();
    {hist, sh, sa, rd, drv, bit_q, wr} = '0;
    {ph, n, frames, errs, need} = '0;
    prev = 4'hF;
    t77p = 1'b1;
    since = 1000;
  endtask : restart

  initial restart();
  always @(posedge rst) restart();

  // Decode one finished 16-bit packet
  task automatic packet();
    n = 0;
    case (ph)
      1:
      begin
        frames++;
        op = sh[9:6];
        sel = sh[5] || ({sh[10], sh[4:0]} == regs[`SA_INIT][5:0]);
        if (sh[15:11] != 5'h00) errs++;
        if (since <= need) errs++;
        if ((prev == 4'h2) != (op == 4'hB)) errs++;
        prev = op;
        wr = op[0];
        need = 0;
        since = 0;
        ph = 0;
        case (op)
          4'h0, 4'h1: ph = 2;
          4'h2:
          begin
            wipe();
            need = 16;
          end
          4'h4: need = 4;
          4'hB: need = 4;
          4'hF: ;
          default: errs++;
        endcase
      end
      2:
      begin
        sa = sh;
        if (sa[15:12] != 4'h0) errs++;
        if (t77p && !(wr && sa[11:0] == `SA_T77)) errs++;
        ph = wr ? 3 : 4;
      end
      3:
      begin
        if (sel) regs[sa[11:0]] = sh;
        if (sel && sa[11:0] == `SA_T77 && sh == 16'h0) t77p = 1'b0;
        ph = 4;
      end
      default:
      begin
        if (sh != 16'h0) errs++;
        rd = regs.exists(sa[11:0]) ? regs[sa[11:0]] : 16'h0;
        ph = (!wr && sel) ? 5 : 0;
      end
    endcase
  endtask : packet

  // Falling edge: frame start and packet bits
  always @(negedge sck)
  begin
    hist = {hist[6:0], cmd};
    if (ph == 0)
    begin
      since++;
      if (cmd && !hist[1])
      begin
        ph = 1;
        n = 0;
      end
    end
    if (ph >= 1 && ph <= 4)
    begin
      sh = {sh[14:0], sio};
      n++;
      if (n == 16) packet();
    end
  end

  // Rising edge: frame pattern check and read data out
  always @(posedge sck)
  begin
    hist = {hist[6:0], cmd};
    if (ph == 1 && n == 4 && hist != `FRAME_PAT) errs++;
    if (ph == 5)
    begin
      if (n < 16)
      begin
        drv = 1'b1;
        bit_q = rd[15 - n];
        n++;
      end
      else
      begin
        drv = 1'b0;
        ph = 0;
        since = 0;
      end
    end
  end
endmodule : sio_dev_model

// >>> verification/sio_ctrl_tb.sv
// Self-checking bench for the serial control-port host
`include "sio_ctrl_params.svh"
module sio_ctrl_tb;
  import sio_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] INIT_RST = 16'h00BF;
  logic        clk, rst, psel, pen, pwr, pready, pslverr;
  logic        sck, cmd, sio_o, sio_oe, mdl_o, re;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  int          err_count, checks_done, frames, merrs, cyc;

  // Host drives unless it is receiving read data
  wire sio_w = sio_oe ? sio_o : mdl_o;

  sio_ctrl #(.DIV(4)) DUT (
    .CLOCK   (clk),
    .RST     (rst),
    .PSEL    (psel),
    .PENABLE (pen),
    .PWRITE  (pwr),
    .PADDR   (paddr),
    .PWDATA  (pwdata),
    .PRDATA  (prdata),
    .PREADY  (pready),
    .PSLVERR (pslverr),
    .SCK     (sck),
    .CMD     (cmd),
    .SIO_I   (sio_w),
    .SIO_O   (sio_o),
    .SIO_OE  (sio_oe)
  );

  sio_dev_model #(.INIT_RST(INIT_RST)) mdl (
    .rst    (rst),
    .sck    (sck),
    .cmd    (cmd),
    .sio    (sio_w),
    .line_o (mdl_o),
    .rep_o  (),
    .frames (frames),
    .errs   (merrs)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      $display("MISMATCH t=%0t timeout", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // One APB transfer; answer taken at the edge where PREADY is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic idle();
    int k;
    k = 0;
    do
    begin
      apb(1'b0, `A_STAT, 32'h0);
      k++;
    end
    while (rv[0] === 1'b1 && k < 3000);
  endtask : idle

  task automatic sop(input logic [3:0] o, input logic bc, input logic [5:0] dv,
                     input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, `A_ADDR, {20'h0, a});
    apb(1'b1, `A_WDATA, {16'h0, d});
    apb(1'b1, `A_CMD, {14'h0, 2'b01, 2'b0, dv, 3'b0, bc, o});
    idle();
  endtask : sop

  task automatic rdc(input logic bc, input logic [5:0] dv, input logic [11:0] a,
                     input logic [15:0] e);
    sop(`OP_READ, bc, dv, a, 16'h0);
    apb(1'b0, `A_RDATA, 32'h0);
    chk(rv, {16'h0, e}, "read back");
  endtask : rdc

  task automatic t_reset();
    apb(1'b0, `A_STAT, 32'h0);
    chk(rv, 32'h20, "status after reset");
    apb(1'b0, 8'h40, 32'h0);
    chk({re, rv}, {1'b1, 32'h0}, "unmapped read");
    sop(`OP_READ, 1'b1, 6'h0, `SA_CYCLE, 16'h0);
    chk(rv[3], 1'b1, "access before test reg");
    chk(frames, 0, "nothing sent");
    apb(1'b1, `A_STAT, 32'h1E);
    $display("done reset and order");
  endtask : t_reset

  task automatic t_init();
    for (int i = 1; i < 8; i++)
      apb(1'b1, 8'(8'h20 + 4 * i), 32'h1100 + i);
    apb(1'b1, `A_CMD, 32'h0002_0000);
    idle();
    chk(rv[6:0], 7'h40, "init status");
    chk(frames, 10, "init frame count");
    rdc(1'b1, 6'h0, `SA_CYCLE, 16'h0);
    rdc(1'b1, 6'h0, `SA_INIT, INIT_RST);
    $display("done init");
  endtask : t_init

  task automatic t_rw();
    sop(`OP_WRITE, 1'b1, 6'h09, `SA_INIT, 16'h0005);
    sop(`OP_WRITE, 1'b0, 6'h05, `SA_RDTIM, 16'hA5C3);
    rdc(1'b0, 6'h05, `SA_RDTIM, 16'hA5C3);
    sop(`OP_WRITE, 1'b1, 6'h11, `SA_COLDLY, 16'h8001);
    sop(`OP_WRITE, 1'b0, 6'h06, `SA_COLDLY, 16'h2222);
    rdc(1'b0, 6'h05, `SA_COLDLY, 16'h8001);
    sop(`OP_WRITE, 1'b1, 6'h0, `SA_INIT, 16'h0020);
    chk(rv[4], 1'b1, "identifier range");
    rdc(1'b0, 6'h05, `SA_INIT, 16'h0005);
    $display("done read write");
  endtask : t_rw

  task automatic t_ops();
    int f;
    for (int o = 0; o < 16; o++)
      if (!(o inside {0, 1, 2, 4, 15}))
      begin
        f = frames;
        sop(o[3:0], 1'b1, 6'h0, `SA_RDTIM, 16'h0);
        chk(rv[1], 1'b1, "opcode refused");
        chk(frames, f, "refused op sent");
        apb(1'b1, `A_STAT, 32'h1E);
      end
    f = frames;
    sop(`OP_NOP, 1'b1, 6'h0, `SA_RDTIM, 16'h0);
    chk(frames, f + 1, "noop frame");
    rdc(1'b0, 6'h05, `SA_RDTIM, 16'hA5C3);
    sop(`OP_FAST_CLOCK_CMD, 1'b1, 6'h0, 12'h0, 16'h0);
    sop(`OP_SET_RESET_CMD, 1'b1, 6'h0, 12'h0, 16'h0);
    chk(frames, f + 5, "fast_clock_cmd and reset pair");
    rdc(1'b1, 6'h0, `SA_RDTIM, 16'h0);
    rdc(1'b1, 6'h0, `SA_INIT, INIT_RST);
    $display("done opcodes");
  endtask : t_ops

  task automatic t_busy();
    apb(1'b1, `A_ADDR, {20'h0, `SA_NAP_EXIT_REG});
    apb(1'b1, `A_WDATA, 32'h5A5A);
    apb(1'b1, `A_CMD, 32'h0001_0011);
    apb(1'b1, `A_CMD, 32'h0001_0011);
    idle();
    chk(rv[2], 1'b1, "go while busy");
    rdc(1'b1, 6'h0, `SA_NAP_EXIT_REG, 16'h5A5A);
    $display("done busy");
  endtask : t_busy

  task automatic end_sim();
    chk(merrs, 0, "device protocol");
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {psel, pen, pwr, paddr, pwdata} = '0;
    {err_count, checks_done, cyc} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_init();
    t_rw();
    t_ops();
    t_busy();
    end_sim();
  end
endmodule : sio_ctrl_tb
